// [src/count_channel.sv]
// one counted channel: tally, zero-crossing flag, room to count
`timescale 1ns/10ps
`include "evt_agg_regs.svh"

module count_channel #(
  parameter int CNT_W = `EA_CNT_W
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  // count control
  input  wire logic             inc_i,
  input  wire logic             dec_i,
  input  wire logic             take_i,
  // state
  output logic [CNT_W-1:0]      count_o,
  output logic                  pend_o,
  output logic                  room_o
);

  logic [CNT_W-1:0] next_count;
  logic             next_pend;

  // ===================================================================
  // next state
  always_comb begin
    next_count = count_o;
    if (inc_i && !dec_i) begin
      next_count = count_o + CNT_W'(1);
    end else if (dec_i && !inc_i) begin
      next_count = count_o - CNT_W'(1);
    end
    // a crossing in the cycle the old flag leaves still sets it
    next_pend = (pend_o && !take_i) ||
                ((count_o == '0) != (next_count == '0));
  end

  // no counting while a crossing waits, so no crossing is ever lost
  assign room_o = !pend_o && (count_o != {CNT_W{1'b1}});

  // ===================================================================
  // registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_o <= '0;
      pend_o  <= 1'b0;
    end else if (ce_i) begin
      count_o <= next_count;
      pend_o  <= next_pend;
    end
  end

  // ===================================================================
  // checks, one set per channel so every channel is watched
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  cnt_cross_a: assert property (
    ce_i && inc_i && !dec_i && count_o == '0 |=> pend_o && count_o != '0)
    else $error("count leaving zero did not raise an event");

  cnt_ack_a: assert property (
    ce_i && dec_i && !inc_i |=>
      count_o == $past(count_o) - CNT_W'(1) && (count_o != '0 || pend_o))
    else $error("acknowledge did not decrement the count");

endmodule

// [src/event_aggregator.sv]
// event aggregator: status, multicast and counted blocks on one lane
// Notes on behaviour
// - status events set bits driving level interrupts
// - multicast splits one event into up to two
// - counter emits event on zero crossings
// - accumulated count is readable
// - multicast and counted outputs re-enter lane mapped
// - blocked output holds; an event bound for it parks in the input slot, which then refuses new input
`timescale 1ns/10ps
`include "evt_agg_regs.svh"

module event_aggregator #(
  parameter int NUM_CH = `EA_NUM_CH,
  parameter int CNT_W  = `EA_CNT_W
) (
  // clock and reset
  input  wire logic                                clk_i,
  input  wire logic                                rst_i,
  input  wire logic                                ce_i,
  // incoming lane events
  input  wire evt_agg_pkg::lane_event_type         in_evt_i,
  input  wire logic                                in_valid_i,
  output logic                                     in_ready_o,
  // outgoing lane events
  output evt_agg_pkg::lane_event_type              out_evt_o,
  output logic                                     out_valid_o,
  input  wire logic                                out_ready_i,
  // routing maps
  input  wire evt_agg_pkg::lane_event_type [NUM_CH-1:0] mc_route_a_i,
  input  wire evt_agg_pkg::lane_event_type [NUM_CH-1:0] mc_route_b_i,
  input  wire logic [NUM_CH-1:0]                   mc_dual_i,
  input  wire evt_agg_pkg::lane_event_type [NUM_CH-1:0] cnt_route_i,
  // software side
  input  wire logic [NUM_CH-1:0]                   status_clr_i,
  output logic [NUM_CH-1:0]                        irq_o,
  input  wire logic [NUM_CH-1:0]                   cnt_ack_i,
  input  wire logic [`EA_IDX_W-1:0]                cnt_sel_i,
  output logic [CNT_W-1:0]                         cnt_rd_o
);
  import evt_agg_pkg::*;

  // ===================================================================
  // elaboration checks
  if (NUM_CH < 1 || NUM_CH > (1 << `EA_IDX_W)) begin : g_bad_ch
    $error("channel count does not fit the event index");
  end
  if (CNT_W < 1) begin : g_bad_cnt
    $error("count width must be at least one");
  end

  // ===================================================================
  // helpers
  function automatic logic [`EA_IDX_W:0] first_set(input logic [NUM_CH-1:0] vec);
    logic [`EA_IDX_W:0] res;
    res = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (vec[i]) begin
        res = {1'b1, `EA_IDX_W'(i)};
      end
    end
    return res;
  endfunction

  function automatic logic can_take(input lane_event_type ev,
                                    input logic mc_free,
                                    input logic [NUM_CH-1:0] room,
                                    input logic out_free);
    logic ok;
    ok = 1'b0;
    case (ev.tgt)
      TGT_STATUS: ok = 1'b1;
      TGT_MCAST:  ok = mc_free;
      TGT_COUNT:  ok = room[ev.idx];
      TGT_OUT:    ok = out_free;
      default:    ok = 1'b0;
    endcase
    return ok;
  endfunction

  // ===================================================================
  // state
  lane_event_type                  in_evt;
  mc_state_type                    mc_state;
  logic [`EA_IDX_W-1:0]            mc_idx;
  logic [NUM_CH-1:0][CNT_W-1:0]    counts;
  logic [NUM_CH-1:0]               pend;
  logic [NUM_CH-1:0]               room;

  lane_event_type                  next_in_evt;
  logic                            next_in_ready;
  mc_state_type                    next_mc_state;
  logic [`EA_IDX_W-1:0]            next_mc_idx;
  lane_event_type                  next_out_evt;
  logic                            next_out_valid;
  logic [NUM_CH-1:0]               next_irq;
  logic [CNT_W-1:0]                next_rd;

  // dispatch
  logic [`EA_IDX_W:0]              cnt_pick;
  lane_event_type                  cnt_ev;
  lane_event_type                  mc_ev;
  lane_event_type                  d;
  logic                            d_valid;
  logic                            take_cnt;
  logic                            take_mc;
  logic                            take_in;
  logic                            mc_free;
  logic                            out_free;
  logic [NUM_CH-1:0]               set_vec;
  logic [NUM_CH-1:0]               inc_vec;
  logic [NUM_CH-1:0]               dec_ok;
  logic [NUM_CH-1:0]               cnt_take;

  // ===================================================================
  // lane arbitration: internal producers first, so inner paths unwind
  always_comb begin
    mc_free  = (mc_state == MC_IDLE);
    out_free = !out_valid_o || out_ready_i;
    cnt_pick = first_set(pend);
    cnt_ev   = cnt_route_i[cnt_pick[`EA_IDX_W-1:0]];
    mc_ev    = (mc_state == MC_FIRST) ? mc_route_a_i[mc_idx]
                                      : mc_route_b_i[mc_idx];
    take_cnt = 1'b0;
    take_mc  = 1'b0;
    take_in  = 1'b0;
    d        = in_evt;
    if (cnt_pick[`EA_IDX_W] && can_take(cnt_ev, mc_free, room, out_free)) begin
      take_cnt = 1'b1;
      d        = cnt_ev;
    end else if (!mc_free && can_take(mc_ev, mc_free, room, out_free)) begin
      take_mc  = 1'b1;
      d        = mc_ev;
    end else if (!in_ready_o && can_take(in_evt, mc_free, room, out_free)) begin
      take_in  = 1'b1;
    end
    d_valid  = take_cnt || take_mc || take_in;
    set_vec  = '0;
    inc_vec  = '0;
    cnt_take = '0;
    if (d_valid && d.tgt == TGT_STATUS) begin
      set_vec[d.idx] = 1'b1;
    end
    if (d_valid && d.tgt == TGT_COUNT) begin
      inc_vec[d.idx] = 1'b1;
    end
    if (take_cnt) begin
      cnt_take[cnt_pick[`EA_IDX_W-1:0]] = 1'b1;
    end
    // an acknowledge meeting a waiting crossing is dropped
    for (int i = 0; i < NUM_CH; i++) begin
      dec_ok[i] = cnt_ack_i[i] && !pend[i] && (counts[i] != '0);
    end
  end

  // ===================================================================
  // next values
  always_comb begin
    // input slot: one event parked until its target has room
    next_in_evt   = in_evt;
    next_in_ready = in_ready_o;
    if (take_in) begin
      next_in_ready = 1'b1;
    end else if (in_ready_o && in_valid_i) begin
      next_in_evt   = in_evt_i;
      next_in_ready = 1'b0;
    end
    // status bits, a set in the clearing cycle wins
    next_irq = (irq_o & ~status_clr_i) | set_vec;
    // multicast slot
    next_mc_state = mc_state;
    next_mc_idx   = mc_idx;
    case (mc_state)
      MC_IDLE: begin
        if (d_valid && d.tgt == TGT_MCAST) begin
          next_mc_state = MC_FIRST;
          next_mc_idx   = d.idx;
        end
      end
      MC_FIRST: begin
        if (take_mc) begin
          next_mc_state = mc_dual_i[mc_idx] ? MC_SECOND : MC_IDLE;
        end
      end
      MC_SECOND: begin
        if (take_mc) begin
          next_mc_state = MC_IDLE;
        end
      end
      default: next_mc_state = MC_IDLE;
    endcase
    // final output
    next_out_evt   = out_evt_o;
    next_out_valid = out_valid_o && !out_ready_i;
    if (d_valid && d.tgt == TGT_OUT) begin
      next_out_evt   = d;
      next_out_valid = 1'b1;
    end
    next_rd = counts[cnt_sel_i];
  end

  // ===================================================================
  // registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      in_evt      <= '0;
      in_ready_o  <= 1'b1;
      irq_o       <= '0;
      mc_state    <= MC_IDLE;
      mc_idx      <= '0;
      out_evt_o   <= '0;
      out_valid_o <= 1'b0;
      cnt_rd_o    <= '0;
    end else if (ce_i) begin
      in_evt      <= next_in_evt;
      in_ready_o  <= next_in_ready;
      irq_o       <= next_irq;
      mc_state    <= next_mc_state;
      mc_idx      <= next_mc_idx;
      out_evt_o   <= next_out_evt;
      out_valid_o <= next_out_valid;
      cnt_rd_o    <= next_rd;
    end
  end

  // ===================================================================
  // counted channels
  for (genvar g = 0; g < NUM_CH; g++) begin : g_cnt
    count_channel #(
      .CNT_W (CNT_W)
    ) u_cnt (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .ce_i    (ce_i),
      .inc_i   (inc_vec[g]),
      .dec_i   (dec_ok[g]),
      .take_i  (cnt_take[g]),
      .count_o (counts[g]),
      .pend_o  (pend[g]),
      .room_o  (room[g])
    );
  end

  // ===================================================================
  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_mc_first_dual;
    ce_i && take_mc && mc_state == MC_FIRST && mc_dual_i[mc_idx];
  endsequence

  sequence s_mc_second_go;
    ce_i && take_mc && mc_state == MC_SECOND;
  endsequence

  status_set_a: assert property (
    ce_i && set_vec != '0 |=> (irq_o & $past(set_vec)) == $past(set_vec))
    else $error("status event did not raise its interrupt");

  mc_split_a: assert property (
    s_mc_first_dual |=> mc_state == MC_SECOND && mc_idx == $past(mc_idx))
    else $error("dual multicast did not give a second event");

  mc_done_a: assert property (
    s_mc_second_go |=> mc_state == MC_IDLE)
    else $error("multicast slot did not free after its second event");

  cnt_read_a: assert property (
    ce_i |=> cnt_rd_o == $past(counts[cnt_sel_i]))
    else $error("read count does not match the selected channel");

  mc_route_a: assert property (
    ce_i && take_mc && mc_state == MC_FIRST && mc_route_a_i[mc_idx].tgt == TGT_OUT |=>
      out_valid_o && out_evt_o == $past(mc_route_a_i[mc_idx]))
    else $error("multicast output not taken from its map");

  mc_hold_a: assert property (
    ce_i && mc_state != MC_IDLE && !take_mc |=>
      mc_state == $past(mc_state) && mc_idx == $past(mc_idx))
    else $error("blocked multicast slot changed");

  in_hold_a: assert property (
    ce_i && !in_ready_o && !take_in |=> !in_ready_o && in_evt == $past(in_evt))
    else $error("blocked input slot accepted more");

  status_clr_a: assert property (
    ce_i && status_clr_i != '0 |=> (irq_o & $past(status_clr_i & ~set_vec)) == '0)
    else $error("cleared status bit stayed high");

endmodule

// [src/evt_agg_pkg.sv]
// types shared by the event aggregator files
`include "evt_agg_regs.svh"

package evt_agg_pkg;

  // ===================================================================
  // lane event
  typedef enum logic [`EA_TGT_W-1:0] {
    TGT_STATUS = `EA_TGT_STATUS,
    TGT_MCAST  = `EA_TGT_MCAST,
    TGT_COUNT  = `EA_TGT_COUNT,
    TGT_OUT    = `EA_TGT_OUT
  } tgt_type;

  typedef struct packed {
    tgt_type               tgt;
    logic [`EA_IDX_W-1:0]  idx;
  } lane_event_type;

  // ===================================================================
  // multicast slot
  typedef enum logic [1:0] {
    MC_IDLE   = `EA_MC_IDLE,
    MC_FIRST  = `EA_MC_FIRST,
    MC_SECOND = `EA_MC_SECOND
  } mc_state_type;

endpackage

// [src/evt_agg_regs.svh]
// constants for the event aggregator: sizes, target codes, state codes
`ifndef EVT_AGG_REGS_SVH
`define EVT_AGG_REGS_SVH

// =====================================================================
// sizes
`define EA_NUM_CH     16
`define EA_IDX_W      4
`define EA_CNT_W      8
`define EA_TGT_W      2

// =====================================================================
// lane event targets
`define EA_TGT_STATUS 2'h0
`define EA_TGT_MCAST  2'h1
`define EA_TGT_COUNT  2'h2
`define EA_TGT_OUT    2'h3

// =====================================================================
// multicast slot states
`define EA_MC_IDLE    2'h0
`define EA_MC_FIRST   2'h1
`define EA_MC_SECOND  2'h2

`endif

// [testbench/event_aggregator_bench.sv]
// self-checking bench for the event aggregator
`timescale 1ns/10ps

module event_aggregator_bench;
  import evt_agg_pkg::*;

  // ===================================================================
  // signals
  typedef struct {
    lane_event_type evt;
    int             n;
    lane_event_type e0;
    logic [15:0]    irq;
  } row_type;

  logic                       clk_i, rst_i, ce_i, in_valid_i, in_ready_o, out_valid_o;
  logic                       out_ready_i, stall;
  lane_event_type             in_evt_i, out_evt_o;
  lane_event_type [15:0]      mc_route_a_i, mc_route_b_i, cnt_route_i;
  logic [15:0]                mc_dual_i, status_clr_i, irq_o, cnt_ack_i;
  logic [3:0]                 cnt_sel_i;
  logic [7:0]                 cnt_rd_o;
  int                         err_count, comparisons;
  row_type                    rows[7];

  event_aggregator event_aggregator_inst (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .in_evt_i(in_evt_i), .in_valid_i(in_valid_i), .in_ready_o(in_ready_o),
    .out_evt_o(out_evt_o), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
    .mc_route_a_i(mc_route_a_i), .mc_route_b_i(mc_route_b_i), .mc_dual_i(mc_dual_i),
    .cnt_route_i(cnt_route_i), .status_clr_i(status_clr_i), .irq_o(irq_o),
    .cnt_ack_i(cnt_ack_i), .cnt_sel_i(cnt_sel_i), .cnt_rd_o(cnt_rd_o)
  );

  evt_sink evt_sink_inst (
    .clk_i(clk_i), .rst_i(rst_i), .stall_i(stall),
    .evt_i(out_evt_o), .valid_i(out_valid_o), .ready_o(out_ready_i)
  );

  // ===================================================================
  // helpers
  function automatic lane_event_type mk(input tgt_type t, input int i);
    mk.tgt = t;
    mk.idx = i[3:0];
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // holds the event until the edge that sees ready high takes it
  task automatic send(input lane_event_type e);
    int n;
    n = 0;
    while (in_ready_o !== 1'b1 && n < 50) begin
      idle(1);
      n++;
    end
    if (n == 50) chk({15'h0000, in_ready_o}, 16'h0001);
    in_evt_i   = e;
    in_valid_i = 1'b1;
    idle(1);
    in_valid_i = 1'b0;
  endtask

  // pops the oldest accepted event, or flags a missing one
  task automatic take(input lane_event_type e);
    if (evt_sink_inst.seen.size() == 0) begin
      chk(16'hFFFF, {10'h000, e});
    end else begin
      chk({10'h000, evt_sink_inst.seen.pop_front()}, {10'h000, e});
    end
  endtask

  task automatic pulse_ack(input int ch);
    cnt_ack_i[ch] = 1'b1;
    idle(1);
    cnt_ack_i = 16'h0000;
    idle(4);
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ===================================================================
  // clock and watchdog
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    #100000;
    err_count++;
    close_out();
  end

  // ===================================================================
  // main sequence
  initial begin
    err_count = 0;
    comparisons = 0;
    rst_i = 1'b1;
    ce_i = 1'b1;
    in_valid_i = 1'b0;
    in_evt_i = mk(TGT_STATUS, 0);
    stall = 1'b0;
    status_clr_i = 16'h0000;
    cnt_ack_i = 16'h0000;
    cnt_sel_i = 4'h4;
    mc_dual_i = 16'h5555;
    for (int k = 0; k < 16; k++) begin
      mc_route_a_i[k] = mk(TGT_OUT, k);
      mc_route_b_i[k] = mk(TGT_STATUS, k);
      cnt_route_i[k]  = mk(TGT_OUT, 15 - k);
    end
    // even multicast channels split, second copy lands in status bits
    rows[0] = '{mk(TGT_STATUS, 3), 0, mk(TGT_OUT, 0), 16'h0008};
    rows[1] = '{mk(TGT_STATUS, 12), 0, mk(TGT_OUT, 0), 16'h1008};
    rows[2] = '{mk(TGT_OUT, 5), 1, mk(TGT_OUT, 5), 16'h1008};
    rows[3] = '{mk(TGT_MCAST, 2), 1, mk(TGT_OUT, 2), 16'h100C};
    rows[4] = '{mk(TGT_MCAST, 3), 1, mk(TGT_OUT, 3), 16'h100C};
    rows[5] = '{mk(TGT_COUNT, 4), 1, mk(TGT_OUT, 11), 16'h100C};
    rows[6] = '{mk(TGT_MCAST, 6), 1, mk(TGT_OUT, 6), 16'h104C};
    idle(4);
    rst_i = 1'b0;
    chk({15'h0000, in_ready_o}, 16'h0001);
    chk({15'h0000, out_valid_o}, 16'h0000);
    chk(irq_o, 16'h0000);
    chk({8'h00, cnt_rd_o}, 16'h0000);

    // table of ordinary events
    foreach (rows[i]) begin
      send(rows[i].evt);
      idle(10);
      chk(16'(evt_sink_inst.seen.size()), 16'(rows[i].n));
      if (rows[i].n > 0) take(rows[i].e0);
      chk(irq_o, rows[i].irq);
    end

    // clear one bit, the others must stay up; a frozen enable holds it off
    ce_i = 1'b0;
    status_clr_i = 16'h0004;
    idle(3);
    chk(irq_o, 16'h104C);
    ce_i = 1'b1;
    idle(1);
    status_clr_i = 16'h0000;
    idle(2);
    chk(irq_o, 16'h1048);
    status_clr_i = 16'hFFFF;
    idle(1);
    status_clr_i = 16'h0000;
    idle(2);
    chk(irq_o, 16'h0000);

    // counting further above zero emits nothing; acks walk back to zero
    chk({8'h00, cnt_rd_o}, 16'h0001);
    send(mk(TGT_COUNT, 4));
    idle(4);
    send(mk(TGT_COUNT, 4));
    idle(6);
    chk({8'h00, cnt_rd_o}, 16'h0003);
    chk(16'(evt_sink_inst.seen.size()), 16'h0000);
    pulse_ack(4);
    pulse_ack(4);
    chk(16'(evt_sink_inst.seen.size()), 16'h0000);
    chk({8'h00, cnt_rd_o}, 16'h0001);
    pulse_ack(4);
    idle(6);
    chk({8'h00, cnt_rd_o}, 16'h0000);
    chk(16'(evt_sink_inst.seen.size()), 16'h0001);
    take(mk(TGT_OUT, 11));

    // blocked output holds its event, stalls the multicast slot, parks the next one
    stall = 1'b1;
    send(mk(TGT_OUT, 1));
    send(mk(TGT_MCAST, 2));
    send(mk(TGT_OUT, 3));
    idle(8);
    chk({15'h0000, out_valid_o}, 16'h0001);
    chk({10'h000, out_evt_o}, {10'h000, mk(TGT_OUT, 1)});
    chk({15'h0000, in_ready_o}, 16'h0000);
    stall = 1'b0;
    idle(8);
    take(mk(TGT_OUT, 1));
    take(mk(TGT_OUT, 2));
    take(mk(TGT_OUT, 3));
    chk({15'h0000, in_ready_o}, 16'h0001);
    chk(irq_o, 16'h0004);
    close_out();
  end
endmodule

// [testbench/evt_sink.sv]
// far-side consumer of final lane events, able to stall on command
`timescale 1ns/10ps

module evt_sink (
  // clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  // stall request from the bench
  input  wire logic                        stall_i,
  // final output lane
  input  wire evt_agg_pkg::lane_event_type evt_i,
  input  wire logic                        valid_i,
  output logic                             ready_o
);
  import evt_agg_pkg::*;

  // ===================================================================
  // accepted events, oldest first
  lane_event_type seen[$];

  // only the bench may stall us; left alone we always accept
  always_comb ready_o = !stall_i;

  always @(posedge clk_i) begin
    if (!rst_i && valid_i && ready_o) begin
      seen.push_back(evt_i);
    end
  end
endmodule
